// ===== pkg/ccm_pkg.sv
// Shared constants, encodings and lookup tables for the channel mode block
package ccm_pkg;

    // ------------------------------------------------------------------
    // Bus and datapath widths
    // ------------------------------------------------------------------
    localparam int APB_ADDR_W = 8;
    localparam int APB_DATA_W = 32;
    localparam int CNT_W = 16;
    localparam int NUM_CH = 2;
    localparam int MODE_REG_W = 16;

    // ------------------------------------------------------------------
    // Register byte addresses
    // ------------------------------------------------------------------
    localparam logic [APB_ADDR_W-1:0] ADDR_CTRL = 8'h04;
    localparam logic [APB_ADDR_W-1:0] ADDR_EVENT = 8'h14;
    localparam logic [APB_ADDR_W-1:0] ADDR_MODE1 = 8'h18;
    localparam logic [APB_ADDR_W-1:0] ADDR_ENABLE = 8'h20;
    localparam logic [NUM_CH-1:0][APB_ADDR_W-1:0] ADDR_CMP = {8'h38, 8'h34};
    localparam logic [APB_ADDR_W-1:0] ADDR_STATUS = 8'h40;
    localparam logic [MODE_REG_W-1:0] MODE1_RESET = 16'h0000;

    // ------------------------------------------------------------------
    // Mode register fields, per channel byte (channel 2 in the upper byte)
    // ------------------------------------------------------------------
    localparam int CH_FIELD_W = 8;
    localparam int SEL_LSB = 0;
    localparam int FE_BIT = 2;
    localparam int PE_BIT = 3;
    localparam int PSC_LSB = 2;
    localparam int MODE_LSB = 4;
    localparam int FLT_LSB = 4;
    localparam int CE_BIT = 7;
    localparam logic [CH_FIELD_W-1:0] SEL_FIELD_MASK = 8'h03;
    localparam logic [CH_FIELD_W-1:0] LOCKED_FIELD_MASK = 8'h78;

    // ------------------------------------------------------------------
    // Enable/polarity, control and event register fields
    // ------------------------------------------------------------------
    localparam int EN_STRIDE = 4;
    localparam int EN_BIT = 0;
    localparam int POL_BIT = 1;
    localparam int NEN_BIT = 2;
    localparam int NPOL_BIT = 3;
    localparam int CTRL_PCB_BIT = 0;
    localparam int CTRL_OPM_BIT = 1;
    localparam int CTRL_LOCK_LSB = 2;
    localparam int EVENT_COMMUTATION_GENERATE_BIT_BIT = 5;
    localparam logic [1:0] LOCK_LEVEL_3 = 2'h3;

    // ------------------------------------------------------------------
    // Encodings
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        CCM_SEL_OUTPUT = 2'b00,
        CCM_SEL_OWN_PIN = 2'b01,
        CCM_SEL_NEIGHBOUR_PIN = 2'b10,
        CCM_SEL_INT_TRIGGER = 2'b11
    } ccm_sel_type;

    typedef enum logic [2:0] {
        CCM_OC_FROZEN = 3'b000,
        CCM_OC_SET_ON_MATCH = 3'b001,
        CCM_OC_CLEAR_ON_MATCH = 3'b010,
        CCM_OC_TOGGLE = 3'b011,
        CCM_OC_FORCE_LOW = 3'b100,
        CCM_OC_FORCE_HIGH = 3'b101,
        CCM_OC_PWM1 = 3'b110,
        CCM_OC_PWM2 = 3'b111
    } ccm_oc_mode_type;

    // ------------------------------------------------------------------
    // Filter tables indexed by filter code: sample divider mask and N
    // ------------------------------------------------------------------
    localparam logic [15:0][4:0] FLT_DIV_MASK = {
        5'h1F, 5'h1F, 5'h1F, 5'h0F, 5'h0F, 5'h0F, 5'h07, 5'h07,
        5'h03, 5'h03, 5'h01, 5'h01, 5'h00, 5'h00, 5'h00, 5'h00};
    localparam logic [15:0][3:0] FLT_N = {
        4'h8, 4'h6, 4'h5, 4'h8, 4'h6, 4'h5, 4'h8, 4'h6,
        4'h8, 4'h6, 4'h8, 4'h6, 4'h8, 4'h4, 4'h2, 4'h1};

    // Capture prescaler: last count value before a capture, by code
    localparam logic [3:0][2:0] PSC_LAST = {3'h7, 3'h3, 3'h1, 3'h0};

endpackage

// ===== rtl/ccm_channel_mode.sv
// Capture/compare mode logic for channels 1 and 2 with an APB register slave
//
// What this block does
// - Channel 1 select: 00 output, 01 own pin, 10 neighbour pin, 11 trigger.
// - Channel 2 select in bits 9:8, filter 15:12; fields mirror channel 1.
// - Select field is written only while the channel enable bit is 0.
// - Clear enable set: high external trigger clears the reference.
// - Modes 000 frozen, 001 set, 010 clear, 011 toggle on match.
// - Mode 100 holds reference low, 101 holds it high.
// - Mode 110: high below compare counting up, low above counting down.
// - Mode 111 is the inverse of mode 110.
// - Reference is active high; each output applies its own polarity bit.
// - Lock level 3 with output select protects mode and preload bits.
// - PWM reference changes only on compare change or entry from frozen.
// - With preload control set, active mode loads on a commutation event.
// - Compare preload off writes at once; on copies at update events.
// - Fast enable 0: trigger does not disturb the normal compare output.
// - Fast enable 1 in PWM: trigger forces compare level, 3 cycles.
// - Filter output changes after N consecutive samples of the new level.
// - Filter 0000 unfiltered; 0001-0011 kernel clock with N of 2, 4, 8.
// - Filter 0100-1111 divide the sample clock by 2 to 32 with N.
// - Capture prescaler captures every 1, 2, 4 or 8 edges.
// - Capture prescaler count clears while the channel enable bit is 0.
// - Commutation bit self-clears and loads buffered enable and mode bits.
`timescale 1ns/10ps
module ccm_channel_mode (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ccm_pkg::APB_ADDR_W-1:0] paddr,
    input wire logic [ccm_pkg::APB_DATA_W-1:0] pwdata,
    output logic pready,
    output logic [ccm_pkg::APB_DATA_W-1:0] prdata,
    output logic pslverr,
    input wire logic timer_input_pin_one,
    input wire logic timer_input_pin_two,
    input wire logic internal_trigger_source,
    input wire logic filtered_external_trigger,
    input wire logic trigger_edge,
    input wire logic update_event,
    input wire logic count_down,
    input wire logic [ccm_pkg::CNT_W-1:0] counter_value,
    output logic ch1_main_output,
    output logic ch1_complementary_output,
    output logic ch2_main_output,
    output logic ch2_complementary_output,
    output logic ch1_capture_event,
    output logic ch2_capture_event
);
    import ccm_pkg::*;

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [NUM_CH-1:0][2:0] pin_sync;
        logic [NUM_CH-1:0] pin_stable;
        logic [MODE_REG_W-1:0] mode_reg;
        logic preload_control_bit;
        logic one_pulse_select;
        logic [1:0] lock_level;
        logic [CH_FIELD_W-1:0] enable_pre;
        logic [CH_FIELD_W-1:0] enable_act;
        logic [NUM_CH-1:0][2:0] act_mode;
        logic [NUM_CH-1:0][CNT_W-1:0] cmp_buf;
        logic [NUM_CH-1:0][CNT_W-1:0] cmp_act;
        logic commutation_generate_bit;
        logic trig;
        logic [NUM_CH-1:0] cap_prev;
        logic [NUM_CH-1:0][2:0] psc_cnt;
        logic [NUM_CH-1:0] cap_evt;
        logic [NUM_CH-1:0] out_main;
        logic [NUM_CH-1:0] out_comp;
        logic pready;
        logic [APB_DATA_W-1:0] prdata;
        logic pslverr;
    } ccm_top_state_type;

    ccm_top_state_type q;
    ccm_top_state_type d;

    logic [NUM_CH-1:0] pin_raw;
    logic [NUM_CH-1:0] filt;
    logic [NUM_CH-1:0] ref_lvl;
    logic [NUM_CH-1:0] cap_src;
    logic [NUM_CH-1:0] cap_edge;
    logic bus_access;
    logic wr_hit;
    logic commutation_event;
    logic mapped;
    logic [APB_DATA_W-1:0] rd_data;
    logic [CH_FIELD_W-1:0] old_byte;
    logic [CH_FIELD_W-1:0] keep_mask;
    logic [CH_FIELD_W-1:0] en_bits;
    logic [1:0] sel;

    assign pin_raw = {timer_input_pin_two, timer_input_pin_one};

    // ------------------------------------------------------------------
    // Per-channel filter and reference generator
    // ------------------------------------------------------------------
    for (genvar c = 0; c < NUM_CH; c++)
    begin : g_ch
        ccm_input_filter u_filter (
            .sys_clk(sys_clk),
            .srst(srst),
            .din(q.pin_stable[c]),
            .code(q.mode_reg[c*CH_FIELD_W+FLT_LSB +: 4]),
            .dout(filt[c])
        );

        ccm_oc_ref u_ref (
            .sys_clk(sys_clk),
            .srst(srst),
            .mode(ccm_oc_mode_type'(q.act_mode[c])),
            .clear_en(q.mode_reg[c*CH_FIELD_W+CE_BIT]),
            .ext_clear(filtered_external_trigger),
            .fast_en(q.mode_reg[c*CH_FIELD_W+FE_BIT]),
            .trig(q.trig),
            .count_down(count_down),
            .counter(counter_value),
            .compare(q.cmp_act[c]),
            .ref_out(ref_lvl[c])
        );
    end

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    always_comb
    begin
        d = q;
        cap_src = '0;
        cap_edge = '0;
        old_byte = '0;
        keep_mask = '0;
        en_bits = '0;
        sel = '0;
        mapped = 1'b1;
        rd_data = '0;

        // Pins pass three stages; a level counts once stages two and three agree
        for (int c = 0; c < NUM_CH; c++)
        begin
            d.pin_sync[c] = {q.pin_sync[c][1:0], pin_raw[c]};
            if (q.pin_sync[c][1] == q.pin_sync[c][2])
            begin
                d.pin_stable[c] = q.pin_sync[c][2];
            end
        end

        // One register stage on the trigger keeps the fast path at three cycles
        d.trig = trigger_edge;

        // APB: one wait state, so pready and read data come from flops
        bus_access = psel && penable;
        d.pready = bus_access && !q.pready;
        wr_hit = bus_access && q.pready && pwrite;

        // Commutation request lives one cycle, then hardware clears it
        commutation_event = q.commutation_generate_bit;
        d.commutation_generate_bit = 1'b0;
        if (wr_hit && (paddr == ADDR_EVENT))
        begin
            d.commutation_generate_bit = pwdata[EVENT_COMMUTATION_GENERATE_BIT_BIT];
        end

        // Control and enable registers
        if (wr_hit && (paddr == ADDR_CTRL))
        begin
            d.preload_control_bit = pwdata[CTRL_PCB_BIT];
            d.one_pulse_select = pwdata[CTRL_OPM_BIT];
            d.lock_level = pwdata[CTRL_LOCK_LSB +: 2];
        end
        if (wr_hit && (paddr == ADDR_ENABLE))
        begin
            d.enable_pre = pwdata[CH_FIELD_W-1:0];
        end

        // Mode register write with per-field protection
        for (int c = 0; c < NUM_CH; c++)
        begin
            old_byte = q.mode_reg[c*CH_FIELD_W +: CH_FIELD_W];
            keep_mask = '0;
            if (q.enable_pre[c*EN_STRIDE+EN_BIT])
            begin
                keep_mask = keep_mask | SEL_FIELD_MASK;
            end
            if ((q.lock_level == LOCK_LEVEL_3) && (old_byte[SEL_LSB +: 2] == CCM_SEL_OUTPUT))
            begin
                keep_mask = keep_mask | LOCKED_FIELD_MASK;
            end
            if (wr_hit && (paddr == ADDR_MODE1))
            begin
                d.mode_reg[c*CH_FIELD_W +: CH_FIELD_W] =
                    (old_byte & keep_mask) | (pwdata[c*CH_FIELD_W +: CH_FIELD_W] & ~keep_mask);
            end
        end

        // Active copies: follow at once, or wait for commutation under preload control
        if (!q.preload_control_bit || commutation_event)
        begin
            d.enable_act = q.enable_pre;
            for (int c = 0; c < NUM_CH; c++)
            begin
                d.act_mode[c] = q.mode_reg[c*CH_FIELD_W+MODE_LSB +: 3];
            end
        end

        // Compare values: buffer always written, active copy by preload setting
        for (int c = 0; c < NUM_CH; c++)
        begin
            if (update_event && q.mode_reg[c*CH_FIELD_W+PE_BIT])
            begin
                d.cmp_act[c] = q.cmp_buf[c];
            end
            if (wr_hit && (paddr == ADDR_CMP[c]))
            begin
                d.cmp_buf[c] = pwdata[CNT_W-1:0];
                if (!q.mode_reg[c*CH_FIELD_W+PE_BIT])
                begin
                    d.cmp_act[c] = pwdata[CNT_W-1:0];
                end
            end
        end

        // Input routing, edge detection and capture prescaler
        for (int c = 0; c < NUM_CH; c++)
        begin
            sel = q.mode_reg[c*CH_FIELD_W+SEL_LSB +: 2];
            en_bits = q.enable_act >> (c * EN_STRIDE);
            unique case (ccm_sel_type'(sel))
                CCM_SEL_OUTPUT: cap_src[c] = 1'b0;
                CCM_SEL_OWN_PIN: cap_src[c] = filt[c];
                CCM_SEL_NEIGHBOUR_PIN: cap_src[c] = filt[NUM_CH-1-c];
                CCM_SEL_INT_TRIGGER: cap_src[c] = internal_trigger_source;
            endcase
            d.cap_prev[c] = cap_src[c];
            // Polarity bit picks the capture edge: 0 rising, 1 falling
            cap_edge[c] = en_bits[POL_BIT] ? (q.cap_prev[c] && !cap_src[c]) : (!q.cap_prev[c] && cap_src[c]);
            d.cap_evt[c] = 1'b0;
            if (!en_bits[EN_BIT])
            begin
                d.psc_cnt[c] = '0;
            end
            else if ((sel != CCM_SEL_OUTPUT) && cap_edge[c])
            begin
                if (q.psc_cnt[c] == PSC_LAST[q.mode_reg[c*CH_FIELD_W+PSC_LSB +: 2]])
                begin
                    d.cap_evt[c] = 1'b1;
                    d.psc_cnt[c] = '0;
                end
                else
                begin
                    d.psc_cnt[c] = q.psc_cnt[c] + 3'h1;
                end
            end

            // Output stage: polarity applied to the active-high reference
            if ((sel == CCM_SEL_OUTPUT) && en_bits[EN_BIT])
            begin
                d.out_main[c] = ref_lvl[c] ^ en_bits[POL_BIT];
            end
            else
            begin
                d.out_main[c] = 1'b0;
            end
            if ((sel == CCM_SEL_OUTPUT) && en_bits[NEN_BIT])
            begin
                d.out_comp[c] = !ref_lvl[c] ^ en_bits[NPOL_BIT];
            end
            else
            begin
                d.out_comp[c] = 1'b0;
            end
        end

        // Read mux; the event register reads as zero since its bit self-clears
        case (paddr)
            ADDR_CTRL:
            begin
                rd_data[CTRL_PCB_BIT] = q.preload_control_bit;
                rd_data[CTRL_OPM_BIT] = q.one_pulse_select;
                rd_data[CTRL_LOCK_LSB +: 2] = q.lock_level;
            end
            ADDR_EVENT: rd_data = '0;
            ADDR_MODE1: rd_data[MODE_REG_W-1:0] = q.mode_reg;
            ADDR_ENABLE: rd_data[CH_FIELD_W-1:0] = q.enable_pre;
            ADDR_CMP[0]: rd_data[CNT_W-1:0] = q.cmp_buf[0];
            ADDR_CMP[1]: rd_data[CNT_W-1:0] = q.cmp_buf[1];
            ADDR_STATUS:
            begin
                rd_data[MODE_REG_W-1:0] = {q.psc_cnt[1], q.psc_cnt[0], q.act_mode[1], q.act_mode[0], filt, ref_lvl};
            end
            default: mapped = 1'b0;
        endcase
        if (d.pready)
        begin
            d.prdata = pwrite ? '0 : rd_data;
            d.pslverr = !mapped;
        end
        else
        begin
            d.prdata = '0;
            d.pslverr = 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    // Reset gives output select, frozen modes, no lock and all channels off
    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            q <= '0;
            q.mode_reg <= MODE1_RESET;
        end
        else
        begin
            q <= d;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign pready = q.pready;
    assign prdata = q.prdata;
    assign pslverr = q.pslverr;
    assign ch1_main_output = q.out_main[0];
    assign ch2_main_output = q.out_main[1];
    assign ch1_complementary_output = q.out_comp[0];
    assign ch2_complementary_output = q.out_comp[1];
    assign ch1_capture_event = q.cap_evt[0];
    assign ch2_capture_event = q.cap_evt[1];

endmodule

// ===== rtl/ccm_input_filter.sv
// Digital input filter: sample-rate divider plus N-sample event counter
`timescale 1ns/10ps
module ccm_input_filter (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic din,
    input wire logic [3:0] code,
    output logic dout
);
    import ccm_pkg::*;

    typedef struct packed {
        logic [4:0] div;
        logic [2:0] run;
        logic out;
    } ccm_flt_state_type;

    ccm_flt_state_type q;
    ccm_flt_state_type d;
    logic tick;

    // ------------------------------------------------------------------
    // Sampling and validation
    // ------------------------------------------------------------------
    // Code 0 has mask 0 and N of 1, so the same path samples every cycle
    always_comb
    begin
        d = q;
        d.div = q.div + 5'h01;
        tick = (q.div & FLT_DIV_MASK[code]) == FLT_DIV_MASK[code];
        if (tick)
        begin
            if (din == q.out)
            begin
                d.run = '0; // Any glitch back restarts the count
            end
            else if (({1'b0, q.run} + 4'h1) == FLT_N[code])
            begin
                d.out = din;
                d.run = '0;
            end
            else
            begin
                d.run = q.run + 3'h1;
            end
        end
    end

    // State register
    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            q <= '0;
        end
        else
        begin
            q <= d;
        end
    end

    assign dout = q.out;

endmodule

// ===== rtl/ccm_oc_ref.sv
// Output compare reference generator for one channel
`timescale 1ns/10ps
module ccm_oc_ref (
    input wire logic sys_clk,
    input wire logic srst,
    input wire ccm_pkg::ccm_oc_mode_type mode,
    input wire logic clear_en,
    input wire logic ext_clear,
    input wire logic fast_en,
    input wire logic trig,
    input wire logic count_down,
    input wire logic [ccm_pkg::CNT_W-1:0] counter,
    input wire logic [ccm_pkg::CNT_W-1:0] compare,
    output logic ref_out
);
    import ccm_pkg::*;

    typedef struct packed {
        logic ref_lvl;
        logic match_prev;
        logic cmp_prev;
        ccm_oc_mode_type mode_prev;
    } ccm_oc_state_type;

    ccm_oc_state_type q;
    ccm_oc_state_type d;
    logic match;
    logic pwm_level;
    logic is_pwm;

    // ------------------------------------------------------------------
    // Reference level
    // ------------------------------------------------------------------
    always_comb
    begin
        d = q;
        match = counter == compare;
        pwm_level = count_down ? !(counter > compare) : (counter < compare);
        if (mode == CCM_OC_PWM2)
        begin
            pwm_level = !pwm_level;
        end
        is_pwm = (mode == CCM_OC_PWM1) || (mode == CCM_OC_PWM2);
        d.match_prev = match;
        d.cmp_prev = pwm_level;
        d.mode_prev = mode;
        // Match modes act on the first cycle of a match only, so a stalled counter toggles once
        unique case (mode)
            CCM_OC_FROZEN: d.ref_lvl = q.ref_lvl;
            CCM_OC_SET_ON_MATCH: if (match && !q.match_prev) d.ref_lvl = 1'b1;
            CCM_OC_CLEAR_ON_MATCH: if (match && !q.match_prev) d.ref_lvl = 1'b0;
            CCM_OC_TOGGLE: if (match && !q.match_prev) d.ref_lvl = !q.ref_lvl;
            CCM_OC_FORCE_LOW: d.ref_lvl = 1'b0;
            CCM_OC_FORCE_HIGH: d.ref_lvl = 1'b1;
            CCM_OC_PWM1, CCM_OC_PWM2:
            begin
                if ((pwm_level != q.cmp_prev) || (q.mode_prev == CCM_OC_FROZEN))
                begin
                    d.ref_lvl = pwm_level;
                end
            end
        endcase
        // Fast trigger acts as a match: the level a match gives in up-count
        if (fast_en && is_pwm && trig)
        begin
            d.ref_lvl = (mode == CCM_OC_PWM2);
        end
        if (clear_en && ext_clear)
        begin
            d.ref_lvl = 1'b0;
        end
    end

    // State register
    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            q <= '{ref_lvl: 1'b0, match_prev: 1'b0, cmp_prev: 1'b0, mode_prev: CCM_OC_FROZEN};
        end
        else
        begin
            q <= d;
        end
    end

    assign ref_out = q.ref_lvl;

endmodule

// ===== test/ccm_channel_mode_bench.sv
// Self-checking bench for the channel mode block
`timescale 1ns/10ps
module ccm_channel_mode_bench;
    import ccm_pkg::*;
    logic sys_clk = 1'b0, srst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic pready, pslverr, o1m, o1c, cap1, cap2, err_q;
    logic pin1 = 1'b0, pin2 = 1'b0, etr = 1'b0, load = 1'b1, trg = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd_q;
    logic [15:0] ld_val = 16'h0000, counter_value;
    int err_total = 0, cmp_count = 0, caps1 = 0, caps2 = 0, b1, b2;
    ccm_channel_mode DUT (.sys_clk, .srst, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata,
        .pslverr, .timer_input_pin_one(pin1), .timer_input_pin_two(pin2), .internal_trigger_source(trg),
        .filtered_external_trigger(etr), .trigger_edge(1'b0), .update_event(1'b0), .count_down(1'b0),
        .counter_value, .ch1_main_output(o1m), .ch1_complementary_output(o1c), .ch2_main_output(),
        .ch2_complementary_output(), .ch1_capture_event(cap1), .ch2_capture_event(cap2));
    ccm_far_model far (.sys_clk, .load, .load_val(ld_val), .counter_value);
    // Free-running 100 MHz clock
    always #5 sys_clk = ~sys_clk;
    // Tally capture pulses so bursts can be judged afterwards
    always @(posedge sys_clk)
    begin
        caps1 <= caps1 + int'(cap1);
        caps2 <= caps2 + int'(cap2);
    end
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
    begin
        cmp_count++;
        if (got !== exp)
        begin
            err_total++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    end
    endtask
    // One APB transfer; waits for pready with no assumed latency
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    begin
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do @(posedge sys_clk); while (pready !== 1'b1);
        rd_q = prdata;
        err_q = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge sys_clk);
    end
    endtask
    // Set mode, enables, trigger and counter, then judge main and complementary outputs
    task automatic step(input logic [7:0] m, input logic [3:0] en, input logic e, input logic [15:0] ld,
        input logic run, input logic [1:0] exp);
    begin
        etr <= e;
        ld_val <= ld;
        apb(1'b1, ADDR_MODE1, {24'h0, m});
        apb(1'b1, ADDR_ENABLE, {28'h0, en});
        load <= !run;
        repeat (run ? 30 : 6) @(posedge sys_clk);
        load <= 1'b1;
        check({30'h0, o1m, o1c}, {30'h0, exp});
    end
    endtask
    task automatic results;
    begin
        $display("errors %0d compares %0d", err_total, cmp_count);
        if (err_total == 0 && cmp_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    end
    endtask
    // Watchdog sized well beyond the roughly 800 cycles the tests need
    initial
    begin
        #200000;
        err_total++;
        results();
    end
    // Main sequence
    initial
    begin
        repeat (12) @(posedge sys_clk);
        srst <= 1'b0;
        @(posedge sys_clk);
        apb(1'b0, ADDR_MODE1, 32'h0);
        check(rd_q, {16'h0, MODE1_RESET});
        apb(1'b0, 8'hFC, 32'h0);
        check({rd_q[30:0], err_q}, 32'h1);
        apb(1'b1, ADDR_MODE1, 32'h3);
        apb(1'b1, ADDR_ENABLE, 32'h1);
        b1 = caps1;
        trg <= 1'b1;
        repeat (4) @(posedge sys_clk);
        check(caps1 - b1, 32'h1);
        apb(1'b1, ADDR_MODE1, 32'h0101);
        apb(1'b0, ADDR_MODE1, 32'h0);
        check(rd_q, 32'h0103);
        // Each prescale code; channel two alternates a passing and a rejecting filter
        for (int k = 0; k < 4; k++)
        begin
            apb(1'b1, ADDR_ENABLE, 32'h0);
            apb(1'b1, ADDR_MODE1, 32'h0101 | 32'(k << 2) | (k[0] ? 32'h3000 : 32'h1000));
            apb(1'b1, ADDR_ENABLE, 32'h11);
            b1 = caps1;
            b2 = caps2;
            repeat (7)
            begin
                pin1 <= 1'b1;
                pin2 <= 1'b1;
                repeat (6) @(posedge sys_clk);
                pin1 <= 1'b0;
                pin2 <= 1'b0;
                repeat (10) @(posedge sys_clk);
            end
            repeat (10) @(posedge sys_clk);
            check(caps1 - b1, 7 >> k);
            check(caps2 - b2, k[0] ? 0 : 7);
        end
        apb(1'b1, ADDR_ENABLE, 32'h0);
        apb(1'b1, ADDR_CTRL, 32'h2);
        step(8'h50, 4'h5, 1'b0, 16'h0, 1'b0, 2'b10);
        apb(1'b1, ADDR_CMP[0], 32'h10);
        step(8'hD0, 4'h5, 1'b1, 16'h0, 1'b0, 2'b01);
        step(8'h50, 4'hF, 1'b0, 16'h0, 1'b0, 2'b01);
        step(8'h40, 4'h5, 1'b0, 16'h0, 1'b0, 2'b01);
        step(8'h00, 4'h5, 1'b0, 16'h0, 1'b0, 2'b01);
        step(8'h60, 4'h5, 1'b0, 16'h8, 1'b0, 2'b10);
        step(8'h60, 4'h5, 1'b0, 16'h20, 1'b0, 2'b01);
        step(8'h00, 4'h5, 1'b0, 16'h20, 1'b0, 2'b01);
        step(8'h70, 4'h5, 1'b0, 16'h20, 1'b0, 2'b10);
        step(8'h40, 4'h5, 1'b0, 16'h0, 1'b0, 2'b01);
        step(8'h10, 4'h5, 1'b0, 16'h0, 1'b1, 2'b10);
        apb(1'b1, ADDR_CTRL, 32'h3);
        apb(1'b1, ADDR_MODE1, 32'h40);
        check({30'h0, o1m, o1c}, 32'h2);
        apb(1'b1, ADDR_EVENT, 32'h20);
        repeat (3) @(posedge sys_clk);
        check({30'h0, o1m, o1c}, 32'h1);
        apb(1'b1, ADDR_CTRL, 32'hE);
        apb(1'b1, ADDR_MODE1, 32'h60);
        apb(1'b0, ADDR_MODE1, 32'h0);
        check(rd_q, 32'h0040);
        results();
    end
endmodule

// ===== test/ccm_channel_mode_chk.sv
// Port assertions for the channel mode block
`timescale 1ns/10ps
module ccm_channel_mode_chk (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic [ccm_pkg::APB_DATA_W-1:0] prdata,
    input wire logic pslverr,
    input wire logic ch1_main_output,
    input wire logic ch1_complementary_output,
    input wire logic ch1_capture_event,
    input wire logic ch2_capture_event
);
    // One clock domain, so clock and reset are given once
    default clocking @(posedge sys_clk);
    endclocking
    default disable iff (srst);
    // Bus answer: one cycle into the access phase, a single cycle long
    chk_ready_slot: assert property (psel && penable && !pready |=> pready)
        else $error("pready late");
    chk_ready_single: assert property (pready |=> !pready)
        else $error("pready held");
    chk_ready_cause: assert property (pready |-> psel && penable)
        else $error("pready without access");
    chk_read_idle: assert property (!pready |-> prdata == '0)
        else $error("prdata not zero");
    chk_err_slot: assert property (pslverr |-> pready)
        else $error("pslverr outside answer");
    // Reset leaves both channel 1 outputs quiet
    chk_reset_quiet: assert property ($past(srst) |-> !(ch1_main_output || ch1_complementary_output))
        else $error("output after reset");
    // Captures are single-cycle pulses
    chk_cap_one: assert property (ch1_capture_event |=> !ch1_capture_event)
        else $error("capture one stuck");
    chk_cap_two: assert property (ch2_capture_event |=> !ch2_capture_event)
        else $error("capture two stuck");
endmodule
bind ccm_channel_mode ccm_channel_mode_chk u_chk (.sys_clk, .srst, .psel, .penable, .pready, .prdata,
    .pslverr, .ch1_main_output, .ch1_complementary_output, .ch1_capture_event, .ch2_capture_event);

// ===== test/ccm_far_model.sv
// Far-side model: the counter that the channel compares against
`timescale 1ns/10ps
module ccm_far_model (
    input wire logic sys_clk,
    input wire logic load,
    input wire logic [15:0] load_val,
    output logic [15:0] counter_value
);
    // Holding load freezes the count, so the bench can park it at any value
    always_ff @(posedge sys_clk)
    begin
        if (load)
            counter_value <= load_val;
        else
            counter_value <= counter_value + 16'h0001;
    end
endmodule
